//--- rtl/halt_reset_pkg.sv
package halt_reset_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned STARTUP_CYCLES = 1024;
  localparam logic [9:0] STARTUP_LOAD = 10'(STARTUP_CYCLES - 1);
  localparam logic [10:0] STARTUP_LEN = 11'(STARTUP_CYCLES);

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_WAKE_MASK = 2'h1;
  localparam logic [1:0] ADDR_CONTROL = 2'h2;
  localparam logic [1:0] ADDR_WAKE_CAUSE = 2'h3;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int STAT_PWRDN_BIT = 0;
  localparam int STAT_TO_BIT = 1;
  localparam int STAT_HALT_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int CTRL_WDTOSC_BIT = 0;
  localparam logic [7:0] WAKE_MASK_RST = 8'hff;
  localparam logic CTRL_WDTOSC_RST = 1'h1;
  localparam logic TO_RST = 1'h0;
  localparam logic PWRDN_RST = 1'h0;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_RUN = 5'h02,
    ST_HALT = 5'h04,
    ST_WAKE = 5'h08,
    ST_INTDLY = 5'h10
  } state_t;

  typedef enum logic [2:0] {
    CAUSE_POWER = 3'h0,
    CAUSE_PIN = 3'h1,
    CAUSE_INT = 3'h2,
    CAUSE_PORT = 3'h3,
    CAUSE_WDT = 3'h4,
    CAUSE_USB = 3'h5
  } cause_t;

endpackage

//--- rtl/halt_wakeup_reset_sequencer.sv
// Summary of operation
// [RQ1] power-down stops the system oscillator; watchdog oscillator runs if chosen
// [RQ2] on-chip RAM and registers are frozen during power-down
// [RQ3] entering power-down restarts watchdog and prescaler on its own oscillator
// [RQ4] I/O ports keep state and configuration during power-down
// [RQ5] power-down instruction sets power-down flag, clears time-out flag
// [RQ6] wake causes: reset pin, interrupt, port A falling edge, watchdog
// [RQ7] reset pin gives full initialisation; watchdog in power-down warm reset
// [RQ8] power-down flag cleared by power-up and watchdog clear, set by halt
// [RQ9] watchdog time-out sets time-out flag; wake resets only PC and SP
// [RQ10] port A bits each enabled to wake; resumes at next instruction
// [RQ11] interrupt wake vectors only if enabled and stack not full
// [RQ12] request already pending at power-down entry cannot wake
// [RQ13] every wake inserts a 1024 system clock wait
// [RQ14] interrupt entry lags the wait by a cycle; next instruction at once
// [RQ15] chip reset from reset pin, watchdog in run, or USB bus reset
// [RQ16] time-out and power-down flags encode the reset cause
// [RQ17] start-up timer adds 1024 cycles on power-up, resets and wakes
// [RQ18] chip reset clears PC, interrupts, watchdog, timer, ports, stack
// [RQ19] port falling edges caught on the clock that keeps running
// [RQ20] after a watchdog wake the watchdog counts again from zero
`timescale 1ns/1ps
module halt_wakeup_reset_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic haltExec,
  input wire logic wdtClearExec,
  input wire logic wdtOverflow,
  input wire logic usbBusReset,
  input wire logic externalResetPin_n,
  input wire logic [7:0] portA,
  input wire logic [1:0] intRequest,
  input wire logic [1:0] intEnable,
  input wire logic globalIntEnable,
  input wire logic stackFull,
  output logic oscillatorRun,
  output logic wdtOscRun,
  output logic coreFreeze,
  output logic chipReset,
  output logic warmReset,
  output logic wdtRestart,
  output logic resumeNext,
  output logic intVector,
  output logic timeoutFlag,
  output logic powerDownFlag,
  output logic haltActive,
  output logic startupBusy
);

  typedef struct packed {
    halt_reset_pkg::state_t state;
    halt_reset_pkg::cause_t cause;
    logic pwrDown;
    logic to;
    logic [7:0] wakeMask;
    logic wdtOscSel;
    logic [1:0] reqAtHalt;
    logic [7:0] portPrev;
    logic wakeToInt;
    logic sstStart;
    logic oscRun;
    logic freeze;
    logic chipReset;
    logic warmReset;
    logic wdtRestart;
    logic resumeNext;
    logic intVector;
    logic [7:0] rdata;
  } ctl_t;

  ctl_t ctl_reg;
  ctl_t ctl_next;
  logic sstDone;
  logic sstBusy;
  logic [7:0] portFall;
  logic [1:0] newReq;
  logic intWake;
  logic intTake;

  function automatic logic regHit(input logic [1:0] a,
                                  input logic [1:0] off);
    regHit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // start-up delay
  // ---------------------------------------------------------------
  startup_delay_timer u_startup (
    .clk(clk),
    .reset_n(reset_n),
    .start(ctl_reg.sstStart),
    .busy(sstBusy),
    .done(sstDone)
  );

  // ---------------------------------------------------------------
  // wake sources
  // ---------------------------------------------------------------
  // edges sampled on clk, which stays up while the core clock is gated
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_port
      assign portFall[gi] = ctl_reg.portPrev[gi] & ~portA[gi]
                            & ctl_reg.wakeMask[gi]; // RQ10 RQ19
    end
  endgenerate

  // requests pending at entry are masked out
  assign newReq = intRequest & ~ctl_reg.reqAtHalt; // RQ12
  assign intWake = |newReq;
  assign intTake = globalIntEnable & |(newReq & intEnable)
                   & ~stackFull; // RQ11

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.sstStart = 1'b0;
    ctl_next.warmReset = 1'b0;
    ctl_next.wdtRestart = 1'b0;
    ctl_next.resumeNext = 1'b0;
    ctl_next.intVector = 1'b0;
    ctl_next.portPrev = portA;
    ctl_next.rdata = 8'h00;

    if (!externalResetPin_n) begin
      // full init, held while the pin is low
      ctl_next.state = halt_reset_pkg::ST_RESET; // RQ7 RQ15
      ctl_next.cause = halt_reset_pkg::CAUSE_PIN;
      ctl_next.chipReset = 1'b1; // RQ18
      ctl_next.sstStart = 1'b1; // RQ17
      ctl_next.oscRun = 1'b1;
      ctl_next.freeze = 1'b0;
      ctl_next.wdtRestart = 1'b1;
      if (ctl_reg.state == halt_reset_pkg::ST_HALT) begin
        ctl_next.to = 1'b0; // RQ16
        ctl_next.pwrDown = 1'b0;
      end
    end else if (usbBusReset) begin
      ctl_next.state = halt_reset_pkg::ST_RESET; // RQ15
      ctl_next.cause = halt_reset_pkg::CAUSE_USB;
      ctl_next.chipReset = 1'b1; // RQ18
      ctl_next.sstStart = 1'b1;
      ctl_next.oscRun = 1'b1;
      ctl_next.freeze = 1'b0;
      if (ctl_reg.state == halt_reset_pkg::ST_HALT) begin
        ctl_next.to = 1'b0;
        ctl_next.pwrDown = 1'b1;
      end
    end else begin
      unique case (ctl_reg.state)
        halt_reset_pkg::ST_RESET: begin
          if (sstDone) begin
            ctl_next.state = halt_reset_pkg::ST_RUN;
            ctl_next.chipReset = 1'b0;
          end
        end
        halt_reset_pkg::ST_RUN: begin
          if (wdtOverflow) begin
            ctl_next.state = halt_reset_pkg::ST_RESET; // RQ15
            ctl_next.cause = halt_reset_pkg::CAUSE_WDT;
            ctl_next.chipReset = 1'b1;
            ctl_next.sstStart = 1'b1; // RQ17
            ctl_next.wdtRestart = 1'b1;
            ctl_next.to = 1'b1; // RQ9 RQ16
          end else if (haltExec) begin
            // halt wins over a watchdog clear in the same cycle
            ctl_next.state = halt_reset_pkg::ST_HALT;
            ctl_next.pwrDown = 1'b1; // RQ5 RQ8
            ctl_next.to = 1'b0; // RQ5
            ctl_next.oscRun = 1'b0; // RQ1
            ctl_next.freeze = 1'b1; // RQ2 RQ4
            ctl_next.reqAtHalt = intRequest; // RQ12
            ctl_next.wdtRestart = ctl_reg.wdtOscSel; // RQ3
          end else if (wdtClearExec) begin
            ctl_next.pwrDown = 1'b0; // RQ8
          end
        end
        halt_reset_pkg::ST_HALT: begin
          if (wdtOverflow) begin
            ctl_next.state = halt_reset_pkg::ST_WAKE; // RQ6
            ctl_next.cause = halt_reset_pkg::CAUSE_WDT;
            ctl_next.to = 1'b1; // RQ9 RQ16
            ctl_next.pwrDown = 1'b1;
            ctl_next.warmReset = 1'b1; // RQ7 RQ9
            ctl_next.wdtRestart = 1'b1; // RQ20
            ctl_next.wakeToInt = 1'b0;
            ctl_next.sstStart = 1'b1; // RQ13
            ctl_next.oscRun = 1'b1;
          end else if (|portFall) begin
            ctl_next.state = halt_reset_pkg::ST_WAKE; // RQ6 RQ10
            ctl_next.cause = halt_reset_pkg::CAUSE_PORT;
            ctl_next.wakeToInt = 1'b0;
            ctl_next.sstStart = 1'b1; // RQ13
            ctl_next.oscRun = 1'b1;
          end else if (intWake) begin
            ctl_next.state = halt_reset_pkg::ST_WAKE; // RQ6
            ctl_next.cause = halt_reset_pkg::CAUSE_INT;
            ctl_next.wakeToInt = intTake; // RQ11
            ctl_next.sstStart = 1'b1; // RQ13
            ctl_next.oscRun = 1'b1;
          end
        end
        halt_reset_pkg::ST_WAKE: begin
          if (sstDone) begin
            ctl_next.freeze = 1'b0;
            if (ctl_reg.wakeToInt) begin
              ctl_next.state = halt_reset_pkg::ST_INTDLY; // RQ14
            end else begin
              ctl_next.state = halt_reset_pkg::ST_RUN;
              ctl_next.resumeNext = 1'b1; // RQ14
            end
          end
        end
        halt_reset_pkg::ST_INTDLY: begin
          ctl_next.state = halt_reset_pkg::ST_RUN;
          ctl_next.intVector = 1'b1; // RQ14
        end
        default: begin
          ctl_next.state = halt_reset_pkg::ST_RESET;
          ctl_next.chipReset = 1'b1;
          ctl_next.sstStart = 1'b1;
        end
      endcase
    end

    // register port
    if (regWrite && regHit(regAddr, halt_reset_pkg::ADDR_WAKE_MASK)) begin
      ctl_next.wakeMask = regWriteData;
    end
    if (regWrite && regHit(regAddr, halt_reset_pkg::ADDR_CONTROL)) begin
      ctl_next.wdtOscSel = regWriteData[halt_reset_pkg::CTRL_WDTOSC_BIT];
    end
    if (regRead) begin
      if (regHit(regAddr, halt_reset_pkg::ADDR_STATUS)) begin
        ctl_next.rdata[halt_reset_pkg::STAT_PWRDN_BIT] = ctl_reg.pwrDown;
        ctl_next.rdata[halt_reset_pkg::STAT_TO_BIT] = ctl_reg.to;
        ctl_next.rdata[halt_reset_pkg::STAT_HALT_BIT] =
          (ctl_reg.state == halt_reset_pkg::ST_HALT);
        ctl_next.rdata[halt_reset_pkg::STAT_BUSY_BIT] = sstBusy;
      end else if (regHit(regAddr, halt_reset_pkg::ADDR_WAKE_MASK)) begin
        ctl_next.rdata = ctl_reg.wakeMask;
      end else if (regHit(regAddr, halt_reset_pkg::ADDR_CONTROL)) begin
        ctl_next.rdata[halt_reset_pkg::CTRL_WDTOSC_BIT] = ctl_reg.wdtOscSel;
      end else begin
        ctl_next.rdata = {5'h00, ctl_reg.cause};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg <= '0;
      ctl_reg.state <= halt_reset_pkg::ST_RESET;
      ctl_reg.cause <= halt_reset_pkg::CAUSE_POWER;
      ctl_reg.pwrDown <= halt_reset_pkg::PWRDN_RST; // RQ8
      ctl_reg.to <= halt_reset_pkg::TO_RST;
      ctl_reg.wakeMask <= halt_reset_pkg::WAKE_MASK_RST;
      ctl_reg.wdtOscSel <= halt_reset_pkg::CTRL_WDTOSC_RST;
      ctl_reg.portPrev <= 8'hff;
      ctl_reg.sstStart <= 1'b1; // RQ17
      ctl_reg.oscRun <= 1'b1;
      ctl_reg.chipReset <= 1'b1; // RQ18
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign regReadData = ctl_reg.rdata;
  assign oscillatorRun = ctl_reg.oscRun;
  assign wdtOscRun = ctl_reg.wdtOscSel;
  assign coreFreeze = ctl_reg.freeze;
  assign chipReset = ctl_reg.chipReset;
  assign warmReset = ctl_reg.warmReset;
  assign wdtRestart = ctl_reg.wdtRestart;
  assign resumeNext = ctl_reg.resumeNext;
  assign intVector = ctl_reg.intVector;
  assign timeoutFlag = ctl_reg.to;
  assign powerDownFlag = ctl_reg.pwrDown;
  assign haltActive = (ctl_reg.state == halt_reset_pkg::ST_HALT);
  assign startupBusy = sstBusy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic runQuiet;
  logic haltQuiet;
  assign runQuiet = (ctl_reg.state == halt_reset_pkg::ST_RUN)
                    & externalResetPin_n & ~usbBusReset & ~wdtOverflow;
  assign haltQuiet = (ctl_reg.state == halt_reset_pkg::ST_HALT)
                     & externalResetPin_n & ~usbBusReset & ~wdtOverflow;

  property p_halt_flags;
    @(posedge clk) disable iff (!reset_n)
    runQuiet && haltExec |=> powerDownFlag && !timeoutFlag && haltActive;
  endproperty
  a_halt_flags: assert property (p_halt_flags) // RQ5
    else $error("halt entry flags wrong");

  property p_osc_off;
    @(posedge clk) disable iff (!reset_n)
    haltActive |-> !oscillatorRun && coreFreeze;
  endproperty
  a_osc_off: assert property (p_osc_off) // RQ1
    else $error("oscillator or freeze wrong in power-down");

  property p_wdt_restart;
    @(posedge clk) disable iff (!reset_n)
    runQuiet && haltExec && wdtOscRun |=> wdtRestart ##1 !wdtRestart;
  endproperty
  a_wdt_restart: assert property (p_wdt_restart) // RQ3
    else $error("watchdog not restarted on halt");

  property p_clear_pdf;
    @(posedge clk) disable iff (!reset_n)
    runQuiet && !haltExec && wdtClearExec |=> !powerDownFlag;
  endproperty
  a_clear_pdf: assert property (p_clear_pdf) // RQ8
    else $error("watchdog clear left power-down flag");

  property p_warm_wake;
    @(posedge clk) disable iff (!reset_n)
    ctl_reg.state == halt_reset_pkg::ST_HALT && wdtOverflow
      && externalResetPin_n && !usbBusReset
    |=> warmReset && wdtRestart && timeoutFlag && powerDownFlag
        && !chipReset ##1 startupBusy;
  endproperty
  a_warm_wake: assert property (p_warm_wake) // RQ9
    else $error("watchdog wake did not warm reset");

  property p_pin_reset;
    @(posedge clk) disable iff (!reset_n)
    !externalResetPin_n |=> chipReset ##1 (startupBusy && chipReset);
  endproperty
  a_pin_reset: assert property (p_pin_reset) // RQ15
    else $error("reset pin did not reset chip");

  property p_pending_blocked;
    @(posedge clk) disable iff (!reset_n)
    haltQuiet && portFall == 8'h00 && newReq == 2'h0 |=> haltActive;
  endproperty
  a_pending_blocked: assert property (p_pending_blocked) // RQ12
    else $error("woke without a new cause");

  property p_port_wake;
    @(posedge clk) disable iff (!reset_n)
    haltQuiet && |portFall |=> !haltActive && oscillatorRun
      ##1 startupBusy;
  endproperty
  a_port_wake: assert property (p_port_wake) // RQ10
    else $error("port edge did not wake");

  property p_int_after_wait;
    @(posedge clk) disable iff (!reset_n)
    $rose(intVector) |-> !startupBusy && $past(!startupBusy, 2);
  endproperty
  a_int_after_wait: assert property (p_int_after_wait) // RQ14
    else $error("interrupt entry not delayed after wait");

endmodule // halt_wakeup_reset_sequencer

//--- rtl/startup_delay_timer.sv
`timescale 1ns/1ps
module startup_delay_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [9:0] count;
    logic busy;
    logic done;
  } startup_t;

  startup_t timer_reg;
  startup_t timer_next;
  logic [10:0] busyLen;

  // ---------------------------------------------------------------
  // count down, a start reloads at any time
  // ---------------------------------------------------------------
  always_comb begin
    timer_next = timer_reg;
    timer_next.done = 1'b0;
    if (start) begin
      timer_next.count = halt_reset_pkg::STARTUP_LOAD;
      timer_next.busy = 1'b1;
    end else if (timer_reg.busy) begin
      if (timer_reg.count == 10'h000) begin
        timer_next.busy = 1'b0;
        timer_next.done = 1'b1;
      end else begin
        timer_next.count = timer_reg.count - 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_next;
    end
  end

  assign busy = timer_reg.busy;
  assign done = timer_reg.done;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busyLen <= 11'h000;
    end else if (start) begin
      busyLen <= 11'h000;
    end else if (timer_reg.busy) begin
      busyLen <= busyLen + 11'h001;
    end
  end

  property p_startup_length;
    @(posedge clk) disable iff (!reset_n)
    $fell(busy) |-> busyLen == halt_reset_pkg::STARTUP_LEN;
  endproperty
  a_startup_length: assert property (p_startup_length) // RQ17
    else $error("start-up delay not 1024 cycles");

  property p_startup_done;
    @(posedge clk) disable iff (!reset_n)
    $fell(busy) |-> done ##1 !done;
  endproperty
  a_startup_done: assert property (p_startup_done) // RQ13
    else $error("start-up done pulse wrong");

endmodule // startup_delay_timer

//--- tb/halt_wake_partner.sv
`timescale 1ns/1ps
module halt_wake_partner (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pinHold,
  input wire logic [7:0] fallBits,
  output logic externalResetPin_n,
  output logic [7:0] portA
);
  // ---------------------------------------------------------------
  // pins with pull-ups: a released line reads high
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      externalResetPin_n <= 1'h1;
      portA <= 8'hff;
    end else begin
      externalResetPin_n <= ~pinHold;
      portA <= ~fallBits;
    end
  end
endmodule // halt_wake_partner

//--- tb/tb_halt_wakeup_reset_sequencer.sv
`timescale 1ns/1ps
module tb_halt_wakeup_reset_sequencer;
  logic clk, reset_n, regWrite, regRead, haltExec, wdtClearExec;
  logic wdtOverflow, usbBusReset, globalIntEnable, stackFull, pinHold;
  logic [1:0] regAddr, intRequest, intEnable;
  logic [7:0] regWriteData, regReadData, portA, fallBits;
  logic externalResetPin_n, oscillatorRun, wdtOscRun, coreFreeze;
  logic chipReset, warmReset, wdtRestart, resumeNext, intVector;
  logic timeoutFlag, powerDownFlag, haltActive, startupBusy;
  logic rdPend = 1'h0;
  logic [7:0] expQ[$];
  logic [31:0] r;
  int err_count = 0;
  int n_tests = 0;
  integer seed = 32'ha61e27ed;
  int n, b, k;

  halt_wakeup_reset_sequencer dut_u (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData), .haltExec(haltExec),
    .wdtClearExec(wdtClearExec), .wdtOverflow(wdtOverflow),
    .usbBusReset(usbBusReset), .externalResetPin_n(externalResetPin_n),
    .portA(portA), .intRequest(intRequest), .intEnable(intEnable),
    .globalIntEnable(globalIntEnable), .stackFull(stackFull),
    .oscillatorRun(oscillatorRun), .wdtOscRun(wdtOscRun),
    .coreFreeze(coreFreeze), .chipReset(chipReset), .warmReset(warmReset),
    .wdtRestart(wdtRestart), .resumeNext(resumeNext),
    .intVector(intVector), .timeoutFlag(timeoutFlag),
    .powerDownFlag(powerDownFlag), .haltActive(haltActive),
    .startupBusy(startupBusy));

  halt_wake_partner farSide_u (.clk(clk), .reset_n(reset_n),
    .pinHold(pinHold), .fallBits(fallBits),
    .externalResetPin_n(externalResetPin_n), .portA(portA));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // compare, bus and event tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rdPend <= regRead;
  always @(negedge clk) begin
    if (rdPend && expQ.size() > 0) begin
      check(regReadData, expQ.pop_front(), "read data");
    end
  end

  task automatic wrReg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask

  task automatic rdReg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'h0;
  endtask

  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: haltExec <= 1'h1;
      1: wdtOverflow <= 1'h1;
      2: wdtClearExec <= 1'h1;
      default: usbBusReset <= 1'h1;
    endcase
    @(posedge clk);
    haltExec <= 1'h0;
    wdtOverflow <= 1'h0;
    wdtClearExec <= 1'h0;
    usbBusReset <= 1'h0;
    #1;
  endtask

  function automatic logic sigOf(input int s);
    case (s)
      0: return startupBusy;
      1: return chipReset;
      2: return resumeNext;
      3: return intVector;
      default: return haltActive;
    endcase
  endfunction

  task automatic waitSig(input int s, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && sigOf(s) !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    if (sigOf(s) !== lvl) begin
      err_count++;
      $display("wrong value at %0t: wait ran out", $time);
      results();
    end
  endtask

  task automatic halt(input logic [31:0] e);
    pulse(0);
    check({haltActive, powerDownFlag, timeoutFlag, oscillatorRun,
           coreFreeze, wdtRestart}, e, "halt entry");
  endtask

  task automatic portPulse(input int p);
    @(posedge clk);
    fallBits <= 8'h01 << p;
    repeat (3) @(posedge clk);
    fallBits <= 8'h00;
    #1;
  endtask

  // counts the start-up wait, then expects the resume kind
  task automatic startWait(input logic viaInt);
    n = 0;
    waitSig(0, 1'h1, 8);
    while (startupBusy === 1'h1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, 1024, "start-up length");
    waitSig(viaInt ? 3 : 2, 1'h1, 4);
    check({coreFreeze, oscillatorRun}, 2'h1, "run again");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {regWrite, regRead, haltExec, wdtClearExec, wdtOverflow} = 5'h00;
    {usbBusReset, stackFull, pinHold, reset_n} = 4'h0;
    globalIntEnable = 1'h1;
    {regAddr, intRequest} = 4'h0;
    intEnable = 2'h3;
    {regWriteData, fallBits} = 16'h0000;
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    rdReg(halt_reset_pkg::ADDR_WAKE_MASK, 8'hff);
    rdReg(halt_reset_pkg::ADDR_CONTROL, 8'h01);
    waitSig(1, 1'h0, 1100);
    rdReg(halt_reset_pkg::ADDR_STATUS, 8'h00);
    $display("test power-up done");

    b = $unsigned($random(seed)) % 8;
    wrReg(halt_reset_pkg::ADDR_WAKE_MASK, 8'h01 << b);
    wrReg(halt_reset_pkg::ADDR_CONTROL, 8'h00);
    halt(32'h32);
    portPulse((b + 1) % 8);
    repeat (40) @(posedge clk);
    #1;
    check(haltActive, 1'h1, "masked bit");
    portPulse(b);
    startWait(1'h0);
    rdReg(halt_reset_pkg::ADDR_WAKE_CAUSE, 8'h03);
    r = $random(seed);
    wrReg(halt_reset_pkg::ADDR_WAKE_MASK, r[7:0]);
    rdReg(halt_reset_pkg::ADDR_WAKE_MASK, r[7:0]);
    wrReg(halt_reset_pkg::ADDR_WAKE_MASK, 8'hff);
    wrReg(halt_reset_pkg::ADDR_CONTROL, 8'h01);
    wrReg(halt_reset_pkg::ADDR_STATUS, 8'hff);
    rdReg(halt_reset_pkg::ADDR_STATUS, 8'h01);
    $display("test port wake done");

    intRequest <= 2'h1;
    halt(32'h33);
    repeat (40) @(posedge clk);
    #1;
    check(haltActive, 1'h1, "pending request");
    portPulse(0);
    startWait(1'h0);
    for (k = 0; k < 4; k++) begin
      intEnable <= (k == 1) ? 2'h0 : 2'h3;
      stackFull <= (k == 2);
      globalIntEnable <= (k != 3);
      intRequest <= 2'h0;
      halt(32'h33);
      intRequest <= 2'h2;
      startWait(k == 0);
      rdReg(halt_reset_pkg::ADDR_WAKE_CAUSE, 8'h02);
    end
    intRequest <= 2'h0;
    $display("test interrupt wake done");

    halt(32'h33);
    pulse(1);
    check({warmReset, wdtRestart, timeoutFlag, powerDownFlag, chipReset},
          5'h1e, "watchdog wake");
    startWait(1'h0);
    rdReg(halt_reset_pkg::ADDR_WAKE_CAUSE, 8'h04);
    pulse(2);
    rdReg(halt_reset_pkg::ADDR_STATUS, 8'h02);
    pulse(1);
    check({chipReset, timeoutFlag, powerDownFlag}, 3'h6, "watchdog run");
    waitSig(1, 1'h0, 1100);
    $display("test watchdog done");

    halt(32'h33);
    pinHold <= 1'h1;
    repeat (5) @(posedge clk);
    #1;
    check({chipReset, timeoutFlag, powerDownFlag}, 3'h4, "pin reset");
    @(posedge clk);
    pinHold <= 1'h0;
    waitSig(1, 1'h0, 1100);
    rdReg(halt_reset_pkg::ADDR_WAKE_CAUSE, 8'h01);
    pulse(3);
    check(chipReset, 1'h1, "usb reset");
    waitSig(1, 1'h0, 1100);
    rdReg(halt_reset_pkg::ADDR_WAKE_CAUSE, 8'h05);
    repeat (2) @(posedge clk);
    $display("test chip resets done");
    results();
  end
endmodule // tb_halt_wakeup_reset_sequencer
